// ---- rtl/usb_dev_pkg.sv ----
package usb_dev_pkg;
  // ----------------------------------------------------------------
  // timing
  // ----------------------------------------------------------------
  localparam int CLK_KHZ = 40000;
  localparam int SUSPEND_IDLE_MS = 3;
  localparam int RESUME_IDLE_MS = 5;
  localparam int RESUME_DRIVE_MS = 1;
  localparam int SUSPEND_CYCLES = SUSPEND_IDLE_MS * CLK_KHZ;
  localparam int RESUME_IDLE_CYCLES = RESUME_IDLE_MS * CLK_KHZ;
  localparam int RESUME_DRIVE_CYCLES = RESUME_DRIVE_MS * CLK_KHZ;
  localparam int TIMER_W = 20;
  // ----------------------------------------------------------------
  // sizes
  // ----------------------------------------------------------------
  localparam int NUM_EP = 2;
  localparam int EP_W = 1;
  localparam int CNT_W = 7;
  localparam int ADDR_W = 7;
  localparam int PADDR_W = 8;
  localparam logic [CNT_W-1:0] EP_SIZE = 7'h40;
  // ----------------------------------------------------------------
  // register map
  // ----------------------------------------------------------------
  localparam logic [7:0] CTRL_OFF = 8'h00;
  localparam logic [7:0] ADDR_OFF = 8'h04;
  localparam logic [7:0] STAT_OFF = 8'h08;
  localparam logic [7:0] STAT_CLR_OFF = 8'h0C;
  localparam logic [7:0] EP_BASE_OFF = 8'h20;
  localparam logic [7:0] EP_END_OFF = 8'h40;
  localparam logic [3:0] EP_STA_SUB = 4'h0;
  localparam logic [3:0] EP_CTL_SUB = 4'h4;
  localparam logic [3:0] EP_ENA_SUB = 4'h8;
  localparam logic [3:0] EP_FIFO_SUB = 4'hC;
  // ----------------------------------------------------------------
  // fields
  // ----------------------------------------------------------------
  localparam int CTRL_MACRO_EN = 0;
  localparam int CTRL_FREEZE = 1;
  localparam int CTRL_DETACH = 2;
  localparam int CTRL_RMWAKE = 3;
  localparam int ADDR_EN_BIT = 7;
  localparam int ST_SUSPEND = 0;
  localparam int ST_WAKE = 1;
  localparam int ST_UPRES = 2;
  localparam int ST_EORES = 3;
  localparam int ST_EORST = 4;
  localparam int EPF_IN_READY = 0;
  localparam int EPF_OUT_RX = 1;
  localparam int EPF_SETUP_RX = 2;
  localparam int EPF_STALLED = 3;
  localparam int EPF_NAKED_IN = 4;
  localparam int EPF_HALT = 5;
  localparam int EPF_BANK_CTL = 6;
  localparam int EPF_RW_ALLOWED = 7;
  localparam int EPF_COUNT_LSB = 8;
  localparam int EPC_HALT_SET = 5;
  localparam int EPC_HALT_CLR = 6;
  localparam int EPC_BANK_CLR = 7;
  localparam int EPC_KILL = 8;
  localparam int ENA_IN_READY = 0;
  // ----------------------------------------------------------------
  // reset values
  // ----------------------------------------------------------------
  localparam logic FREEZE_RST = 1'b1;
  localparam logic DETACH_RST = 1'b1;
  // ----------------------------------------------------------------
  // types
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {PID_SETUP, PID_OUT, PID_IN} token_type;
  typedef enum logic [1:0] {HS_ACK, HS_NAK, HS_STALL, HS_DATA} handshake_type;
  typedef enum logic [1:0] {CTRL_IDLE, CTRL_DATA_IN, CTRL_STATUS} ctrl_stage_type;
endpackage

// ---- rtl/usb_device_endpoint_control.sv ----
// What this block does
// - address zero answered after any reset
// - enabled address filters incoming tokens
// - resets and disable clear address, enable
// - suspend flag after 3 ms idle
// - wake on non-idle; flags clear each other
// - detach resets high, removes pull-up
// - resume request only once suspended
// - resume sent after 5 ms inactivity
// - resume flags, request cleared at end
// - halted endpoint stalls, discards, sets only the stall flag
// - halt cleared by clear-bit or SETUP; stall flagged
// - SETUP on halted control endpoint ACKed, clears halt
// - retry beats stall
// - SETUP on control endpoint always ACKed; control bank bits read zero
// - first status token NAKed, CPU data dropped
// - OUT retry ACKed, sets both flags; ZLP clears count
// - free bank sets in-ready with bank control
// - bank-control clear commits bank, moves on
// - rw-allowed while bank not full
// - kill-bank drops last written bank
module usb_device_endpoint_control #(
  parameter int SUSPEND_COUNT = usb_dev_pkg::SUSPEND_CYCLES,
  parameter int RESUME_IDLE_COUNT = usb_dev_pkg::RESUME_IDLE_CYCLES,
  parameter int RESUME_DRIVE_COUNT = usb_dev_pkg::RESUME_DRIVE_CYCLES
) (
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic clk_en,
  input wire logic [usb_dev_pkg::PADDR_W-1:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic bus_idle,
  input wire logic bus_reset,
  input wire logic host_eor,
  input wire logic tok_valid,
  input wire usb_dev_pkg::token_type tok_pid,
  input wire logic [usb_dev_pkg::ADDR_W-1:0] tok_addr,
  input wire logic [3:0] tok_ep,
  input wire logic tok_zero_len,
  output logic hs_valid,
  output usb_dev_pkg::handshake_type hs_code,
  output logic fifo_wr,
  output logic [7:0] fifo_wdata,
  output logic pullup_en,
  output logic resume_drive,
  output logic freeze_clock,
  output logic [usb_dev_pkg::NUM_EP-1:0] endpoint_interrupt
);
  import usb_dev_pkg::*;

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  typedef struct packed {
    logic idle_s1;
    logic idle_s2;
    logic idle_d;
    logic macro_enable;
    logic freeze_clock;
    logic detach;
    logic remote_wake_request;
    logic [ADDR_W-1:0] stored_device_address;
    logic address_enable;
    logic suspend_flag;
    logic bus_wake_flag;
    logic upstream_resume_flag;
    logic end_of_resume_flag;
    logic end_of_reset_flag;
    logic resume_drive;
    logic [TIMER_W-1:0] timer;
    logic [NUM_EP-1:0] in_ready_flag;
    logic [NUM_EP-1:0] out_received_flag;
    logic [NUM_EP-1:0] setup_received_flag;
    logic [NUM_EP-1:0] stalled_flag;
    logic [NUM_EP-1:0] naked_in_flag;
    logic [NUM_EP-1:0] halt_request;
    logic [NUM_EP-1:0] in_ready_enable;
    ctrl_stage_type stage;
    logic ctrl_in_pending;
    logic [CNT_W-1:0] ctrl_count;
    logic [1:0] bank_busy;
    logic bank_wr;
    logic bank_rd;
    logic bank_control;
    logic [CNT_W-1:0] bank_byte_count;
    logic hs_valid;
    handshake_type hs_code;
    logic [31:0] prdata;
    logic fifo_wr;
    logic [7:0] fifo_wdata;
  } state_type;

  localparam logic [TIMER_W-1:0] SUSPEND_FLAG_LAST = TIMER_W'(SUSPEND_COUNT - 1);
  localparam logic [TIMER_W-1:0] WAKE_T = TIMER_W'(RESUME_IDLE_COUNT);
  localparam logic [TIMER_W-1:0] DRIVE_LAST = TIMER_W'(RESUME_DRIVE_COUNT - 1);

  state_type s_reg;
  state_type s_next;
  logic idle;
  logic rw_allowed;
  logic [ADDR_W-1:0] eff_addr;

  function automatic logic is_ep(input logic [PADDR_W-1:0] a);
    return (a >= EP_BASE_OFF) && (a < EP_END_OFF) && (a[1:0] == 2'b00);
  endfunction

  function automatic logic [EP_W-1:0] ep_of(input logic [PADDR_W-1:0] a);
    return EP_W'(a[7:4] - EP_BASE_OFF[7:4]);
  endfunction

  function automatic logic addr_hit(input logic [PADDR_W-1:0] a);
    return is_ep(a) || a == CTRL_OFF || a == ADDR_OFF || a == STAT_OFF || a == STAT_CLR_OFF;
  endfunction

  assign idle = s_reg.idle_s2;
  assign eff_addr = s_reg.address_enable ? s_reg.stored_device_address : '0;
  assign rw_allowed = s_reg.bank_control && (s_reg.bank_byte_count < EP_SIZE);

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  always_comb begin
    handshake_type hs;
    logic fire;
    logic [EP_W-1:0] we;
    logic [EP_W-1:0] te;
    logic lw;
    hs = HS_NAK;
    fire = 1'b0;
    we = '0;
    te = tok_ep[EP_W-1:0];
    lw = 1'b0;
    s_next = s_reg;
    s_next.idle_s1 = bus_idle;
    s_next.idle_s2 = s_reg.idle_s1;
    s_next.idle_d = s_reg.idle_s2;
    s_next.hs_valid = 1'b0;
    s_next.fifo_wr = 1'b0;

    // read data is captured in the setup phase so the access needs no wait
    if (psel && !penable && !pwrite) begin
      s_next.prdata = '0;
      if (is_ep(paddr)) begin
        we = ep_of(paddr);
        case (paddr[3:0])
          EP_STA_SUB: begin
            s_next.prdata[EPF_IN_READY] = s_reg.in_ready_flag[we];
            s_next.prdata[EPF_OUT_RX] = s_reg.out_received_flag[we];
            s_next.prdata[EPF_SETUP_RX] = s_reg.setup_received_flag[we];
            s_next.prdata[EPF_STALLED] = s_reg.stalled_flag[we];
            s_next.prdata[EPF_NAKED_IN] = s_reg.naked_in_flag[we];
            s_next.prdata[EPF_HALT] = s_reg.halt_request[we];
            if (we != '0) begin
              s_next.prdata[EPF_BANK_CTL] = s_reg.bank_control;
              s_next.prdata[EPF_RW_ALLOWED] = rw_allowed;
              s_next.prdata[EPF_COUNT_LSB+:CNT_W] = s_reg.bank_byte_count;
            end else begin
              s_next.prdata[EPF_COUNT_LSB+:CNT_W] = s_reg.ctrl_count;
            end
          end
          EP_ENA_SUB: s_next.prdata[ENA_IN_READY] = s_reg.in_ready_enable[we];
          default: ;
        endcase
      end else begin
        case (paddr)
          CTRL_OFF: begin
            s_next.prdata[CTRL_MACRO_EN] = s_reg.macro_enable;
            s_next.prdata[CTRL_FREEZE] = s_reg.freeze_clock;
            s_next.prdata[CTRL_DETACH] = s_reg.detach;
            s_next.prdata[CTRL_RMWAKE] = s_reg.remote_wake_request;
          end
          ADDR_OFF: begin
            s_next.prdata[ADDR_W-1:0] = s_reg.stored_device_address;
            s_next.prdata[ADDR_EN_BIT] = s_reg.address_enable;
          end
          STAT_OFF: begin
            s_next.prdata[ST_SUSPEND] = s_reg.suspend_flag;
            s_next.prdata[ST_WAKE] = s_reg.bus_wake_flag;
            s_next.prdata[ST_UPRES] = s_reg.upstream_resume_flag;
            s_next.prdata[ST_EORES] = s_reg.end_of_resume_flag;
            s_next.prdata[ST_EORST] = s_reg.end_of_reset_flag;
          end
          default: ;
        endcase
      end
    end

    // ----------------------------------------------------------------
    // register writes; hardware events below override clears
    // ----------------------------------------------------------------
    if (psel && penable && pwrite) begin
      if (is_ep(paddr)) begin
        we = ep_of(paddr);
        case (paddr[3:0])
          EP_CTL_SUB: begin
            if (pwdata[EPF_IN_READY]) begin
              if (we != '0) begin
                s_next.in_ready_flag[we] = 1'b0;
              end else if (s_reg.stage != CTRL_STATUS) begin
                s_next.in_ready_flag[0] = 1'b0;
                s_next.ctrl_in_pending = 1'b1;
              end
            end
            if (pwdata[EPF_OUT_RX]) s_next.out_received_flag[we] = 1'b0;
            if (pwdata[EPF_SETUP_RX]) s_next.setup_received_flag[we] = 1'b0;
            if (pwdata[EPF_STALLED]) s_next.stalled_flag[we] = 1'b0;
            if (pwdata[EPF_NAKED_IN]) s_next.naked_in_flag[we] = 1'b0;
            if (pwdata[EPC_HALT_CLR]) s_next.halt_request[we] = 1'b0;
            if (pwdata[EPC_HALT_SET]) s_next.halt_request[we] = 1'b1;
            if (we != '0 && pwdata[EPC_BANK_CLR] && s_reg.bank_control) begin
              s_next.bank_busy[s_reg.bank_wr] = 1'b1;
              s_next.bank_wr = ~s_reg.bank_wr;
              s_next.bank_control = 1'b0;
              s_next.in_ready_flag[1] = 1'b0;
              s_next.bank_byte_count = '0;
            end
            if (we != '0 && pwdata[EPC_KILL]) begin
              lw = ~s_next.bank_wr;
              if (s_next.bank_busy[lw]) begin
                s_next.bank_busy[lw] = 1'b0;
                s_next.bank_wr = lw;
                s_next.bank_control = 1'b0;
                s_next.in_ready_flag[1] = 1'b0;
                s_next.bank_byte_count = '0;
              end
            end
          end
          EP_ENA_SUB: s_next.in_ready_enable[we] = pwdata[ENA_IN_READY];
          EP_FIFO_SUB: begin
            if (we != '0) begin
              if (rw_allowed) begin
                s_next.bank_byte_count = CNT_W'(s_reg.bank_byte_count + 1'b1);
                s_next.fifo_wr = 1'b1;
                s_next.fifo_wdata = pwdata[7:0];
              end
            end else if (s_reg.stage != CTRL_STATUS && s_reg.ctrl_count < EP_SIZE) begin
              s_next.ctrl_count = CNT_W'(s_reg.ctrl_count + 1'b1);
              s_next.fifo_wr = 1'b1;
              s_next.fifo_wdata = pwdata[7:0];
            end
          end
          default: ;
        endcase
      end else begin
        case (paddr)
          CTRL_OFF: begin
            s_next.macro_enable = pwdata[CTRL_MACRO_EN];
            s_next.freeze_clock = pwdata[CTRL_FREEZE];
            s_next.detach = pwdata[CTRL_DETACH];
            // a request while not suspended is dropped
            if (pwdata[CTRL_RMWAKE] && s_reg.suspend_flag) s_next.remote_wake_request = 1'b1;
          end
          ADDR_OFF: begin
            s_next.stored_device_address = pwdata[ADDR_W-1:0];
            s_next.address_enable = pwdata[ADDR_EN_BIT];
          end
          STAT_CLR_OFF: begin
            if (pwdata[ST_SUSPEND]) s_next.suspend_flag = 1'b0;
            if (pwdata[ST_WAKE]) s_next.bus_wake_flag = 1'b0;
            if (pwdata[ST_UPRES]) s_next.upstream_resume_flag = 1'b0;
            if (pwdata[ST_EORES]) s_next.end_of_resume_flag = 1'b0;
            if (pwdata[ST_EORST]) s_next.end_of_reset_flag = 1'b0;
          end
          default: ;
        endcase
      end
    end

    // ----------------------------------------------------------------
    // bus activity timer, suspend and remote wake
    // ----------------------------------------------------------------
    if (s_reg.resume_drive) begin
      s_next.timer = TIMER_W'(s_reg.timer + 1'b1);
      if (s_reg.timer == DRIVE_LAST) begin
        s_next.resume_drive = 1'b0;
        s_next.remote_wake_request = 1'b0;
        s_next.timer = '0;
      end
    end else if (idle) begin
      // saturates at the wake count so the suspend point is passed once
      if (s_reg.timer != WAKE_T) s_next.timer = TIMER_W'(s_reg.timer + 1'b1);
      if (s_reg.timer == SUSPEND_FLAG_LAST) begin
        s_next.suspend_flag = 1'b1;
        s_next.bus_wake_flag = 1'b0;
      end
    end else begin
      s_next.timer = '0;
    end
    // own resume signalling is not a wake event
    if (s_reg.idle_d && !idle && !s_reg.resume_drive) begin
      s_next.bus_wake_flag = 1'b1;
      s_next.suspend_flag = 1'b0;
    end
    if (s_reg.remote_wake_request && !s_reg.resume_drive && idle && s_reg.timer == WAKE_T) begin
      s_next.resume_drive = 1'b1;
      s_next.timer = '0;
      s_next.upstream_resume_flag = 1'b1;
      s_next.suspend_flag = 1'b0;
    end
    if (host_eor) s_next.end_of_resume_flag = 1'b1;

    // ----------------------------------------------------------------
    // token handling
    // ----------------------------------------------------------------
    if (tok_valid && tok_addr == eff_addr && tok_ep < 4'(NUM_EP)) begin
      fire = 1'b1;
      case (tok_pid)
        PID_SETUP: begin
          if (te == '0) begin
            hs = HS_ACK;
            s_next.setup_received_flag[0] = 1'b1;
            s_next.halt_request[0] = 1'b0;
            s_next.stalled_flag[0] = 1'b0;
            s_next.out_received_flag[0] = 1'b0;
            s_next.in_ready_flag[0] = 1'b0;
            s_next.ctrl_in_pending = 1'b0;
            s_next.ctrl_count = '0;
            s_next.stage = CTRL_IDLE;
          end else begin
            fire = 1'b0;
          end
        end
        PID_OUT: begin
          if (te == '0) begin
            if (s_reg.stage == CTRL_DATA_IN) begin
              hs = HS_NAK;
              s_next.stage = CTRL_STATUS;
              s_next.ctrl_in_pending = 1'b0;
              s_next.ctrl_count = '0;
            end else if (s_reg.stage == CTRL_STATUS) begin
              hs = HS_ACK;
              s_next.out_received_flag[0] = 1'b1;
              s_next.in_ready_flag[0] = 1'b1;
            end else if (s_reg.out_received_flag[0]) begin
              hs = HS_NAK;
            end else if (s_reg.halt_request[0]) begin
              hs = HS_STALL;
            end else begin
              hs = HS_ACK;
              s_next.out_received_flag[0] = 1'b1;
            end
            if (hs == HS_ACK && tok_zero_len) s_next.ctrl_count = '0;
          end else begin
            hs = s_reg.halt_request[te] ? HS_STALL : HS_NAK;
          end
        end
        PID_IN: begin
          if (te == '0) begin
            if (!s_reg.ctrl_in_pending) begin
              hs = HS_NAK;
              s_next.naked_in_flag[0] = 1'b1;
            end else if (s_reg.halt_request[0]) begin
              hs = HS_STALL;
            end else begin
              hs = HS_DATA;
              s_next.ctrl_in_pending = 1'b0;
              s_next.in_ready_flag[0] = 1'b1;
              s_next.ctrl_count = '0;
              s_next.stage = CTRL_DATA_IN;
            end
          end else if (!s_reg.bank_busy[s_reg.bank_rd]) begin
            hs = HS_NAK;
            s_next.naked_in_flag[te] = 1'b1;
          end else if (s_reg.halt_request[te]) begin
            hs = HS_STALL;
          end else begin
            hs = HS_DATA;
            s_next.bank_busy[s_reg.bank_rd] = 1'b0;
            s_next.bank_rd = ~s_reg.bank_rd;
          end
        end
        default: fire = 1'b0;
      endcase
      if (fire && hs == HS_STALL) s_next.stalled_flag[te] = 1'b1;
      s_next.hs_valid = fire;
      s_next.hs_code = hs;
    end

    // current IN bank free: offer it to firmware
    if (!s_next.bank_control && !s_next.bank_busy[s_next.bank_wr]) begin
      s_next.bank_control = 1'b1;
      s_next.in_ready_flag[1] = 1'b1;
    end

    if (bus_reset) begin
      s_next.stored_device_address = '0;
      s_next.address_enable = 1'b0;
      s_next.stage = CTRL_IDLE;
      s_next.ctrl_in_pending = 1'b0;
      s_next.ctrl_count = '0;
      s_next.end_of_reset_flag = 1'b1;
    end
    // disabled macro holds device state in reset, except the enable, freeze and detach bits and in-ready enables
    if (!s_next.macro_enable) begin
      s_next.stored_device_address = '0;
      s_next.address_enable = 1'b0;
      s_next.suspend_flag = 1'b0;
      s_next.bus_wake_flag = 1'b0;
      s_next.upstream_resume_flag = 1'b0;
      s_next.end_of_resume_flag = 1'b0;
      s_next.end_of_reset_flag = 1'b0;
      s_next.remote_wake_request = 1'b0;
      s_next.resume_drive = 1'b0;
      s_next.timer = '0;
      s_next.in_ready_flag = '0;
      s_next.out_received_flag = '0;
      s_next.setup_received_flag = '0;
      s_next.stalled_flag = '0;
      s_next.naked_in_flag = '0;
      s_next.halt_request = '0;
      s_next.stage = CTRL_IDLE;
      s_next.ctrl_in_pending = 1'b0;
      s_next.ctrl_count = '0;
      s_next.bank_busy = '0;
      s_next.bank_wr = 1'b0;
      s_next.bank_rd = 1'b0;
      s_next.bank_control = 1'b0;
      s_next.bank_byte_count = '0;
      s_next.hs_valid = 1'b0;
    end
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      s_reg <= '0;
      s_reg.freeze_clock <= FREEZE_RST;
      s_reg.detach <= DETACH_RST;
    end else if (clk_en) begin
      s_reg <= s_next;
    end
  end

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  assign pready = 1'b1;
  assign pslverr = psel && penable && !addr_hit(paddr);
  assign prdata = s_reg.prdata;
  assign hs_valid = s_reg.hs_valid;
  assign hs_code = s_reg.hs_code;
  assign fifo_wr = s_reg.fifo_wr;
  assign fifo_wdata = s_reg.fifo_wdata;
  assign pullup_en = s_reg.macro_enable && !s_reg.detach;
  assign resume_drive = s_reg.resume_drive;
  assign freeze_clock = s_reg.freeze_clock;

  for (genvar g = 0; g < NUM_EP; g++) begin : g_int
    assign endpoint_interrupt[g] = s_reg.stalled_flag[g] | s_reg.setup_received_flag[g] |
      s_reg.out_received_flag[g] | (s_reg.in_ready_flag[g] & s_reg.in_ready_enable[g]);
  end
endmodule

// ---- verification/usb_host_model.sv ----
module usb_host_model (
  input wire logic mclk,
  input wire logic hs_valid,
  input wire usb_dev_pkg::handshake_type hs_code,
  output logic bus_idle,
  output logic bus_reset,
  output logic tok_valid,
  output usb_dev_pkg::token_type tok_pid,
  output logic [6:0] tok_addr,
  output logic [3:0] tok_ep
);
  timeunit 1ns;
  timeprecision 1ps;
  import usb_dev_pkg::*;
  initial begin
    {bus_idle, bus_reset, tok_valid, tok_addr, tok_ep} = 14'h0;
    tok_pid = PID_IN;
  end
  // answer read just after its edge; 0 is none
  task automatic send(input token_type p, input logic [6:0] a, input logic [3:0] e,
                      output logic [2:0] r);
    @(posedge mclk);
    tok_valid <= 1'b1;
    tok_pid <= p;
    tok_addr <= a;
    tok_ep <= e;
    @(posedge mclk);
    tok_valid <= 1'b0;
    tok_addr <= ~a;
    #1 r = hs_valid ? {1'b1, hs_code} : 3'b000;
  endtask
  task automatic pulse_reset();
    @(posedge mclk);
    bus_reset <= 1'b1;
    @(posedge mclk);
    bus_reset <= 1'b0;
  endtask
  task automatic idle(input logic v);
    @(posedge mclk);
    bus_idle <= v;
  endtask
endmodule

// ---- verification/usb_device_endpoint_control_asserts.sv ----
module usb_device_endpoint_control_asserts #(
  parameter int RESUME_IDLE_COUNT = usb_dev_pkg::RESUME_IDLE_CYCLES,
  parameter int RESUME_DRIVE_COUNT = usb_dev_pkg::RESUME_DRIVE_CYCLES
) (
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic [usb_dev_pkg::PADDR_W-1:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] pwdata,
  input wire logic bus_idle,
  input wire logic bus_reset,
  input wire logic tok_valid,
  input wire usb_dev_pkg::token_type tok_pid,
  input wire logic [usb_dev_pkg::ADDR_W-1:0] tok_addr,
  input wire logic [3:0] tok_ep,
  input wire logic hs_valid,
  input wire usb_dev_pkg::handshake_type hs_code,
  input wire logic pullup_en,
  input wire logic resume_drive,
  input wire logic freeze_clock,
  input wire logic [usb_dev_pkg::NUM_EP-1:0] endpoint_interrupt
);
  timeunit 1ns;
  timeprecision 1ps;
  import usb_dev_pkg::*;
  logic w, me, det, en;
  logic [6:0] sa, eff;
  logic [19:0] ic, dc;
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rst_n);
  assign w = psel && penable && pwrite;
  assign eff = en ? sa : 7'h00;
  // address and control bits as written
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      {me, det, en, sa, ic, dc} <= {3'b010, 47'h0};
    end else begin
      ic <= bus_idle ? ic + 20'h00001 : 20'h00000;
      dc <= resume_drive ? dc + 20'h00001 : 20'h00000;
      if (w && paddr == CTRL_OFF) begin
        me <= pwdata[CTRL_MACRO_EN];
        det <= pwdata[CTRL_DETACH];
      end
      if (bus_reset || (w && paddr == CTRL_OFF && !pwdata[CTRL_MACRO_EN])) begin
        {sa, en} <= 8'h00;
      end else if (w && paddr == ADDR_OFF && me) begin
        {en, sa} <= pwdata[7:0];
      end
    end
  end
  chk_addr_accept: assert property (
    me && tok_valid && tok_addr == eff && tok_ep == 4'h0 |=> hs_valid) else $error("no answer");
  chk_addr_filter: assert property (
    tok_valid && tok_addr != eff |=> !hs_valid) else $error("foreign address answered");
  chk_pullup_ctl: assert property (
    pullup_en == (me && !det)) else $error("pull-up mismatch");
  chk_reset_pins: assert property (
    $rose(rst_n) |-> freeze_clock && !pullup_en) else $error("bad pins after reset");
  chk_stall_int: assert property (
    hs_valid && hs_code == HS_STALL |-> endpoint_interrupt[$past(tok_ep[0])])
    else $error("stall without interrupt");
  chk_setup_ack: assert property (
    me && tok_valid && tok_pid == PID_SETUP && tok_ep == 4'h0 && tok_addr == eff
    |=> hs_valid && hs_code == HS_ACK) else $error("setup not acked");
  chk_resume_idle: assert property (
    $rose(resume_drive) |-> ic >= RESUME_IDLE_COUNT - 2) else $error("resume too early");
  chk_resume_len: assert property (
    resume_drive |-> dc < RESUME_DRIVE_COUNT) else $error("resume too long");
  chk_resume_end: assert property (
    $fell(resume_drive) |-> dc == RESUME_DRIVE_COUNT) else $error("resume too short");
endmodule
bind usb_device_endpoint_control usb_device_endpoint_control_asserts #(
  .RESUME_IDLE_COUNT(RESUME_IDLE_COUNT), .RESUME_DRIVE_COUNT(RESUME_DRIVE_COUNT)) i_chk (.*);

// ---- verification/usb_device_endpoint_control_tb.sv ----
module usb_device_endpoint_control_tb;
  timeunit 1ns;
  timeprecision 1ps;
  import usb_dev_pkg::*;
  logic mclk = 1'b0, rst_n = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [7:0] paddr = 8'h00, fifo_wdata;
  logic [31:0] pwdata = 32'h0, prdata, d;
  logic pready, pslverr, e, bus_idle, bus_reset, tok_valid, hs_valid, fifo_wr;
  logic pullup_en, resume_drive, freeze_clock, clk_en = 1'b1, host_eor = 1'b0, tok_zero_len = 1'b0;
  logic [6:0] tok_addr;
  logic [3:0] tok_ep;
  logic [2:0] r;
  logic [1:0] endpoint_interrupt;
  token_type tok_pid;
  handshake_type hs_code;
  int n_mismatch = 0, n_tests = 0;
  always #12.5 mclk = ~mclk;
  usb_device_endpoint_control #(.SUSPEND_COUNT(20), .RESUME_IDLE_COUNT(80),
    .RESUME_DRIVE_COUNT(10)) i_usb_device_endpoint_control (.*);
  usb_host_model i_usb_host_model (.*);
  // ----------------------------
  // bus tasks
  // ----------------------------
  task automatic ck(input string n, input logic [31:0] x, input logic [31:0] s);
    n_tests++;
    if (s !== x) begin
      n_mismatch++;
      $display("[FAIL] %s expected %h seen %h", n, x, s);
    end
  endtask
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] wd);
    @(posedge mclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= wd;
    @(posedge mclk);
    penable <= 1'b1;
    do @(posedge mclk); while (pready !== 1'b1);
    d = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    #1;
  endtask
  task automatic final_report();
    $display("comparisons %0d mismatches %0d", n_tests, n_mismatch);
    if (n_mismatch == 0 && n_tests > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  initial begin
    repeat (5000) @(posedge mclk);
    n_mismatch++;
    final_report();
  end
  // ----------------------------
  // scenarios
  // ----------------------------
  initial begin
    repeat (8) @(posedge mclk);
    rst_n <= 1'b1;
    apb(0, CTRL_OFF, 0);
    ck("ctrl", 32'h6, d);
    apb(1, CTRL_OFF, 32'h1);
    ck("pullup", 1, pullup_en);
    apb(0, 8'h10, 0);
    ck("slverr", 1, e);
    i_usb_host_model.send(PID_SETUP, 0, 0, r);
    ck("setup", 3'b100, r);
    apb(0, 8'h20, 0);
    ck("sta0", 32'h4, d & 32'hC6);
    apb(1, 8'h24, 32'h24);
    i_usb_host_model.send(PID_OUT, 0, 0, r);
    ck("stall", 3'b110, r);
    apb(0, 8'h20, 0);
    ck("sta0", 32'h28, d & 32'h2E);
    ck("int0", 1, endpoint_interrupt[0]);
    i_usb_host_model.send(PID_SETUP, 0, 0, r);
    ck("setup", 3'b100, r);
    apb(0, 8'h20, 0);
    ck("sta0", 32'h4, d & 32'h2C);
    apb(1, 8'h24, 32'h24);
    apb(1, 8'h24, 32'h40);
    i_usb_host_model.send(PID_OUT, 0, 0, r);
    ck("out", 3'b100, r);
    apb(1, ADDR_OFF, 32'h05);
    i_usb_host_model.send(PID_SETUP, 7'h05, 0, r);
    ck("addr", 0, r);
    i_usb_host_model.send(PID_IN, 0, 0, r);
    ck("addr", 1, r[2]);
    apb(1, ADDR_OFF, 32'h85);
    i_usb_host_model.send(PID_SETUP, 0, 0, r);
    ck("addr", 0, r);
    i_usb_host_model.send(PID_SETUP, 7'h05, 0, r);
    ck("addr", 3'b100, r);
    i_usb_host_model.pulse_reset();
    i_usb_host_model.send(PID_SETUP, 0, 0, r);
    ck("addr", 3'b100, r);
    apb(1, 8'h38, 32'h1);
    apb(0, 8'h30, 0);
    ck("sta1", 32'hC1, d & 32'h7FFF);
    ck("int1", 1, endpoint_interrupt[1]);
    for (int i = 0; i < 64; i++) apb(1, 8'h3C, i);
    ck("fifo", 9'h13F, {fifo_wr, fifo_wdata});
    apb(0, 8'h30, 0);
    ck("sta1", 32'h4041, d & 32'h7FFF);
    apb(1, 8'h34, 32'h1);
    apb(0, 8'h30, 0);
    ck("sta1", 32'h4040, d & 32'h7FFF);
    apb(1, 8'h34, 32'h80);
    apb(0, 8'h30, 0);
    ck("sta1", 32'hC1, d & 32'h7FFF);
    i_usb_host_model.send(PID_IN, 0, 1, r);
    ck("in1", 3'b111, r);
    i_usb_host_model.idle(1);
    repeat (30) @(posedge mclk);
    apb(0, STAT_OFF, 0);
    ck("stat", 1, d & 3);
    apb(1, CTRL_OFF, 32'h9);
    for (int i = 0; i < 100 && resume_drive !== 1'b1; i++) @(posedge mclk);
    ck("resume", 1, resume_drive);
    apb(0, STAT_OFF, 0);
    ck("stat", 4, d & 5);
    repeat (12) @(posedge mclk);
    apb(0, CTRL_OFF, 0);
    ck("ctrl", 1, d & 9);
    i_usb_host_model.idle(0);
    host_eor <= 1'b1;
    repeat (5) @(posedge mclk) host_eor <= 1'b0;
    apb(0, STAT_OFF, 0);
    ck("stat", 10, d & 11);
    final_report();
  end
endmodule
